// [rtl/dofd_decoder.sv]
// operand field decoder with cpu and dsp status flags
`timescale 1ns/1ps
`default_nettype none
module dofd_decoder
  import dofd_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  input  wire logic        [23:0]   instr_word,
  input  wire logic                 instr_valid,
  input  wire logic                 dsp_field_sel,
  input  wire logic        [4:0]    alu_flag_we,
  input  wire logic        [4:0]    alu_flag_in,
  input  wire logic        [3:0]    dsp_flag_we,
  input  wire logic        [3:0]    dsp_flag_in,
  output logic                      dec_valid,
  output logic                      is_nop,
  output logic             [7:0]    opcode,
  output logic             [3:0]    base_work_reg,
  output logic             [3:0]    src_reg,
  output logic             [2:0]    src_mode,
  output logic             [3:0]    dst_reg,
  output logic             [2:0]    dst_mode,
  output logic                      mode_err,
  output logic             [3:0]    default_working_reg,
  output logic             [12:0]   file_reg_addr,
  output logic                      file_dest_default_working_reg,
  output logic             [3:0]    bit_position_field,
  output logic             [1:0]    operand_size,
  output logic             [9:0]    ten_bit_unsigned_literal,
  output logic                      lit_range_err,
  output logic             [15:0]   ten_bit_signed_literal,
  output logic             [22:0]   program_address_literal,
  output logic                      prog_addr_err,
  output logic                      shadow_sel,
  output logic                      acc_sel,
  output logic             [1:0]    acc_writeback_dest,
  output logic                      awb_en,
  output logic                      awb_indirect,
  output logic             [3:0]    awb_reg,
  output logic             [2:0]    awb_step,
  output logic             [3:0]    mul_reg_a,
  output logic             [3:0]    mul_reg_b,
  output logic                      pair_err,
  output logic             [3:0]    square_operand_reg,
  output logic                      x_pf_en,
  output logic             [3:0]    x_pf_reg,
  output logic signed      [3:0]    x_pf_step,
  output logic                      x_pf_indexed,
  output logic             [3:0]    x_pf_dest,
  output logic                      y_pf_en,
  output logic             [3:0]    y_pf_reg,
  output logic signed      [3:0]    y_pf_step,
  output logic                      y_pf_indexed,
  output logic             [3:0]    y_pf_dest,
  output logic             [3:0]    pf_index_reg,
  output logic                      carry_flag,
  output logic                      digit_carry_flag,
  output logic                      negative_flag,
  output logic                      overflow_flag,
  output logic                      zero_flag,
  output logic                      acc_a_overflow_flag,
  output logic                      acc_b_overflow_flag,
  output logic                      acc_a_saturate_flag,
  output logic                      acc_b_saturate_flag
);
  // combinational decode of the current word
  logic              nxt_is_nop;
  logic        [7:0] nxt_opcode;
  logic        [2:0] nxt_src_mode;
  logic        [2:0] nxt_dst_mode;
  logic              nxt_mode_err;
  logic        [1:0] nxt_size;
  logic              nxt_lit_err;
  logic       [15:0] nxt_slit;
  logic              nxt_prog_err;
  logic              nxt_awb_en;
  logic              nxt_awb_ind;
  logic        [3:0] nxt_mul_a;
  logic        [3:0] nxt_mul_b;
  logic              nxt_pair_err;
  logic        [2:0] pair_code;
  logic        [3:0] x_reg_d;
  logic signed [3:0] x_step_d;
  logic              x_idx_d;
  logic              x_en_d;
  logic        [3:0] y_reg_d;
  logic signed [3:0] y_step_d;
  logic              y_idx_d;
  logic              y_en_d;

  // registered outputs
  logic        dec_valid_ff;
  logic        is_nop_ff;
  logic [7:0]  opcode_ff;
  logic [3:0]  base_ff;
  logic [3:0]  src_reg_ff;
  logic [2:0]  src_mode_ff;
  logic [3:0]  dst_reg_ff;
  logic [2:0]  dst_mode_ff;
  logic        mode_err_ff;
  logic [12:0] file_addr_ff;
  logic        file_default_working_reg_ff;
  logic [3:0]  bit_pos_ff;
  logic [1:0]  size_ff;
  logic [9:0]  ulit_ff;
  logic        lit_err_ff;
  logic [15:0] slit_ff;
  logic [22:0] prog_ff;
  logic        prog_err_ff;
  logic        shadow_ff;
  logic        acc_ff;
  logic [1:0]  awb_code_ff;
  logic        awb_en_ff;
  logic        awb_ind_ff;
  logic [3:0]  mul_a_ff;
  logic [3:0]  mul_b_ff;
  logic        pair_err_ff;
  logic [3:0]  sqr_ff;
  logic        x_en_ff;
  logic [3:0]  x_reg_ff;
  logic [3:0]  x_step_ff;
  logic        x_idx_ff;
  logic [3:0]  x_dest_ff;
  logic        y_en_ff;
  logic [3:0]  y_reg_ff;
  logic [3:0]  y_step_ff;
  logic        y_idx_ff;
  logic [3:0]  y_dest_ff;
  logic [CPU_FLAGS-1:0] cpu_flags_ff;
  logic [DSP_FLAGS-1:0] dsp_flags_ff;

  dofd_prefetch_decode u_x_pf (
    .mode_code (instr_word[XM_HI:XM_LO]),
    .first_reg (REG_W8),
    .addr_reg  (x_reg_d),
    .step      (x_step_d),
    .indexed   (x_idx_d),
    .enable    (x_en_d)
  );

  dofd_prefetch_decode u_y_pf (
    .mode_code (instr_word[YM_HI:YM_LO]),
    .first_reg (REG_W10),
    .addr_reg  (y_reg_d),
    .step      (y_step_d),
    .indexed   (y_idx_d),
    .enable    (y_en_d)
  );

  // all fields are pulled out in parallel; the opcode decides which are used
  always_comb begin
    nxt_opcode   = instr_word[OPC_HI:OPC_LO];
    nxt_is_nop   = (nxt_opcode == NOP_OPCODE);
    nxt_src_mode = instr_word[WS_MODE_HI:WS_MODE_LO];
    nxt_dst_mode = instr_word[WD_MODE_HI:WD_MODE_LO];
    // indexed form only exists on the dsp source/destination fields
    nxt_mode_err = !dsp_field_sel &&
                   ((nxt_src_mode == DOFD_AM_INDEX) || (nxt_src_mode == DOFD_AM_INDEX2) ||
                    (nxt_dst_mode == DOFD_AM_INDEX) || (nxt_dst_mode == DOFD_AM_INDEX2));
    unique case (instr_word[SIZE_HI:SIZE_LO])
      DOFD_SZ_BYTE:  nxt_size = DOFD_SZ_BYTE;
      DOFD_SZ_DWORD: nxt_size = DOFD_SZ_DWORD;
      default:       nxt_size = DOFD_SZ_WORD;
    endcase
    nxt_lit_err  = (nxt_size == DOFD_SZ_BYTE) &&
                   (instr_word[TEN_BIT_UNSIGNED_LITERAL_HI:TEN_BIT_UNSIGNED_LITERAL_LO] > BYTE_LIT_MAX);
    nxt_slit     = {{6{instr_word[TEN_BIT_UNSIGNED_LITERAL_HI]}}, instr_word[TEN_BIT_UNSIGNED_LITERAL_HI:TEN_BIT_UNSIGNED_LITERAL_LO]};
    nxt_prog_err = instr_word[PROGRAM_ADDRESS_LITERAL_LO];
  end

  always_comb begin
    unique case (instr_word[AWB_HI:AWB_LO])
      DOFD_AWB_REG: begin
        nxt_awb_en  = 1'b1;
        nxt_awb_ind = 1'b0;
      end
      DOFD_AWB_POST: begin
        nxt_awb_en  = 1'b1;
        nxt_awb_ind = 1'b1;
      end
      default: begin
        nxt_awb_en  = 1'b0;
        nxt_awb_ind = 1'b0;
      end
    endcase
  end

  // pairs in order 4x5, 4x6, 4x7, 5x6, 5x7, 6x7; codes 6 and 7 are illegal
  always_comb begin
    pair_code    = instr_word[PAIR_HI:PAIR_LO];
    nxt_pair_err = (pair_code > PAIR_MAX);
    nxt_mul_a    = REG_W4;
    nxt_mul_b    = REG_W4 + 4'h1;
    unique case (pair_code)
      3'h0: begin
        nxt_mul_a = REG_W4;
        nxt_mul_b = REG_W4 + 4'h1;
      end
      3'h1: begin
        nxt_mul_a = REG_W4;
        nxt_mul_b = REG_W4 + 4'h2;
      end
      3'h2: begin
        nxt_mul_a = REG_W4;
        nxt_mul_b = REG_W4 + 4'h3;
      end
      3'h3: begin
        nxt_mul_a = REG_W4 + 4'h1;
        nxt_mul_b = REG_W4 + 4'h2;
      end
      3'h4: begin
        nxt_mul_a = REG_W4 + 4'h1;
        nxt_mul_b = REG_W4 + 4'h3;
      end
      3'h5: begin
        nxt_mul_a = REG_W4 + 4'h2;
        nxt_mul_b = REG_W4 + 4'h3;
      end
      default: begin
        nxt_mul_a = REG_W4;
        nxt_mul_b = REG_W4 + 4'h1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dec_valid_ff <= 1'b0;
    end else begin
      dec_valid_ff <= instr_valid;
    end
  end

  // general working register fields and file register forms
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      is_nop_ff    <= 1'b1;
      opcode_ff    <= NOP_OPCODE;
      base_ff      <= 4'h0;
      src_reg_ff   <= 4'h0;
      src_mode_ff  <= 3'h0;
      dst_reg_ff   <= 4'h0;
      dst_mode_ff  <= 3'h0;
      mode_err_ff  <= 1'b0;
      file_addr_ff <= 13'h0000;
      file_default_working_reg_ff <= 1'b0;
      bit_pos_ff   <= 4'h0;
    end else if (instr_valid) begin
      is_nop_ff    <= nxt_is_nop;
      opcode_ff    <= nxt_opcode;
      base_ff      <= instr_word[WB_HI:WB_LO];
      src_reg_ff   <= instr_word[WS_HI:WS_LO];
      src_mode_ff  <= nxt_src_mode;
      dst_reg_ff   <= instr_word[WD_HI:WD_LO];
      dst_mode_ff  <= nxt_dst_mode;
      mode_err_ff  <= nxt_mode_err;
      file_addr_ff <= instr_word[FILE_HI:FILE_LO];
      file_default_working_reg_ff <= instr_word[FILE_DEFAULT_WORKING_REG];
      bit_pos_ff   <= instr_word[BIT_POSITION_FIELD_HI:BIT_POSITION_FIELD_LO];
    end
  end

  // size, literals and shadow select
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      size_ff     <= DOFD_SZ_WORD;
      ulit_ff     <= 10'h000;
      lit_err_ff  <= 1'b0;
      slit_ff     <= 16'h0000;
      prog_ff     <= 23'h000000;
      prog_err_ff <= 1'b0;
      shadow_ff   <= 1'b0;
    end else if (instr_valid) begin
      size_ff     <= nxt_size;
      ulit_ff     <= instr_word[TEN_BIT_UNSIGNED_LITERAL_HI:TEN_BIT_UNSIGNED_LITERAL_LO];
      lit_err_ff  <= nxt_lit_err;
      slit_ff     <= nxt_slit;
      prog_ff     <= instr_word[PROGRAM_ADDRESS_LITERAL_HI:PROGRAM_ADDRESS_LITERAL_LO];
      prog_err_ff <= nxt_prog_err;
      shadow_ff   <= instr_word[SHADOW_BIT];
    end
  end

  // accumulator, write-back and multiply operands
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_ff      <= 1'b0;
      awb_code_ff <= DOFD_AWB_NONE;
      awb_en_ff   <= 1'b0;
      awb_ind_ff  <= 1'b0;
      mul_a_ff    <= REG_W4;
      mul_b_ff    <= REG_W4;
      pair_err_ff <= 1'b0;
      sqr_ff      <= REG_W4;
    end else if (instr_valid) begin
      acc_ff      <= instr_word[ACC_BIT];
      awb_code_ff <= instr_word[AWB_HI:AWB_LO];
      awb_en_ff   <= nxt_awb_en;
      awb_ind_ff  <= nxt_awb_ind;
      mul_a_ff    <= nxt_mul_a;
      mul_b_ff    <= nxt_mul_b;
      pair_err_ff <= nxt_pair_err;
      sqr_ff      <= REG_W4 + {2'b00, instr_word[SQR_HI:SQR_LO]};
    end
  end

  // prefetch address modes and destinations
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      x_en_ff   <= 1'b0;
      x_reg_ff  <= 4'h0;
      x_step_ff <= 4'h0;
      x_idx_ff  <= 1'b0;
      x_dest_ff <= REG_W4;
      y_en_ff   <= 1'b0;
      y_reg_ff  <= 4'h0;
      y_step_ff <= 4'h0;
      y_idx_ff  <= 1'b0;
      y_dest_ff <= REG_W4;
    end else if (instr_valid) begin
      x_en_ff   <= x_en_d;
      x_reg_ff  <= x_reg_d;
      x_step_ff <= x_step_d;
      x_idx_ff  <= x_idx_d;
      x_dest_ff <= REG_W4 + {2'b00, instr_word[XD_HI:XD_LO]};
      y_en_ff   <= y_en_d;
      y_reg_ff  <= y_reg_d;
      y_step_ff <= y_step_d;
      y_idx_ff  <= y_idx_d;
      y_dest_ff <= REG_W4 + {2'b00, instr_word[YD_HI:YD_LO]};
    end
  end

  // flags load per bit from the datapath, independent of decode
  genvar gi;
  generate
    for (gi = 0; gi < CPU_FLAGS; gi++) begin : g_cpu_flag
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          cpu_flags_ff[gi] <= CPU_FLAG_RST[gi];
        end else if (alu_flag_we[gi]) begin
          cpu_flags_ff[gi] <= alu_flag_in[gi];
        end
      end
    end
    for (gi = 0; gi < DSP_FLAGS; gi++) begin : g_dsp_flag
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          dsp_flags_ff[gi] <= DSP_FLAG_RST[gi];
        end else if (dsp_flag_we[gi]) begin
          dsp_flags_ff[gi] <= dsp_flag_in[gi];
        end
      end
    end
  endgenerate

  assign dec_valid                = dec_valid_ff;
  assign is_nop                   = is_nop_ff;
  assign opcode                   = opcode_ff;
  assign base_work_reg            = base_ff;
  assign src_reg                  = src_reg_ff;
  assign src_mode                 = src_mode_ff;
  assign dst_reg                  = dst_reg_ff;
  assign dst_mode                 = dst_mode_ff;
  assign mode_err                 = mode_err_ff;
  assign default_working_reg      = DEFAULT_WORKING_REG_NUM;
  assign file_reg_addr            = file_addr_ff;
  assign file_dest_default_working_reg           = file_default_working_reg_ff;
  assign bit_position_field       = bit_pos_ff;
  assign operand_size             = size_ff;
  assign ten_bit_unsigned_literal = ulit_ff;
  assign lit_range_err            = lit_err_ff;
  assign ten_bit_signed_literal   = slit_ff;
  assign program_address_literal  = prog_ff;
  assign prog_addr_err            = prog_err_ff;
  assign shadow_sel               = shadow_ff;
  assign acc_sel                  = acc_ff;
  assign acc_writeback_dest       = awb_code_ff;
  assign awb_en                   = awb_en_ff;
  assign awb_indirect             = awb_ind_ff;
  assign awb_reg                  = REG_W13;
  assign awb_step                 = AWB_STEP;
  assign mul_reg_a                = mul_a_ff;
  assign mul_reg_b                = mul_b_ff;
  assign pair_err                 = pair_err_ff;
  assign square_operand_reg       = sqr_ff;
  assign x_pf_en                  = x_en_ff;
  assign x_pf_reg                 = x_reg_ff;
  assign x_pf_step                = x_step_ff;
  assign x_pf_indexed             = x_idx_ff;
  assign x_pf_dest                = x_dest_ff;
  assign y_pf_en                  = y_en_ff;
  assign y_pf_reg                 = y_reg_ff;
  assign y_pf_step                = y_step_ff;
  assign y_pf_indexed             = y_idx_ff;
  assign y_pf_dest                = y_dest_ff;
  assign pf_index_reg             = REG_W12;
  assign carry_flag               = cpu_flags_ff[0];
  assign digit_carry_flag         = cpu_flags_ff[1];
  assign negative_flag            = cpu_flags_ff[2];
  assign overflow_flag            = cpu_flags_ff[3];
  assign zero_flag                = cpu_flags_ff[4];
  assign acc_a_overflow_flag      = dsp_flags_ff[0];
  assign acc_b_overflow_flag      = dsp_flags_ff[1];
  assign acc_a_saturate_flag      = dsp_flags_ff[2];
  assign acc_b_saturate_flag      = dsp_flags_ff[3];
endmodule
`default_nettype wire

// [rtl/dofd_pkg.sv]
// constants, field positions and encodings for the operand field decoder
package dofd_pkg;
  localparam int OPC_HI      = 23;
  localparam int OPC_LO      = 16;
  localparam int WB_HI       = 19;
  localparam int WB_LO       = 16;
  localparam int SIZE_HI     = 15;
  localparam int SIZE_LO     = 14;
  localparam int WD_MODE_HI  = 13;
  localparam int WD_MODE_LO  = 11;
  localparam int WD_HI       = 10;
  localparam int WD_LO       = 7;
  localparam int WS_MODE_HI  = 6;
  localparam int WS_MODE_LO  = 4;
  localparam int WS_HI       = 3;
  localparam int WS_LO       = 0;
  localparam int BIT_POSITION_FIELD_HI     = 15;
  localparam int BIT_POSITION_FIELD_LO     = 12;
  localparam int FILE_HI     = 12;
  localparam int FILE_LO     = 0;
  localparam int FILE_DEFAULT_WORKING_REG   = 13;
  localparam int SHADOW_BIT  = 20;
  localparam int TEN_BIT_UNSIGNED_LITERAL_HI    = 13;
  localparam int TEN_BIT_UNSIGNED_LITERAL_LO    = 4;
  localparam int PROGRAM_ADDRESS_LITERAL_HI    = 22;
  localparam int PROGRAM_ADDRESS_LITERAL_LO    = 0;
  localparam int ACC_BIT     = 15;
  localparam int PAIR_HI     = 18;
  localparam int PAIR_LO     = 16;
  localparam int SQR_HI      = 17;
  localparam int SQR_LO      = 16;
  localparam int XD_HI       = 13;
  localparam int XD_LO       = 12;
  localparam int YD_HI       = 11;
  localparam int YD_LO       = 10;
  localparam int XM_HI       = 9;
  localparam int XM_LO       = 6;
  localparam int YM_HI       = 5;
  localparam int YM_LO       = 2;
  localparam int AWB_HI      = 1;
  localparam int AWB_LO      = 0;
  localparam int CPU_FLAGS   = 5;
  localparam int DSP_FLAGS   = 4;

  localparam logic [7:0]  NOP_OPCODE    = 8'h00;
  localparam logic [3:0]  DEFAULT_WORKING_REG_NUM      = 4'h0;
  localparam logic [3:0]  REG_W4        = 4'h4;
  localparam logic [3:0]  REG_W8        = 4'h8;
  localparam logic [3:0]  REG_W10       = 4'hA;
  localparam logic [3:0]  REG_W12       = 4'hC;
  localparam logic [3:0]  REG_W13       = 4'hD;
  localparam logic [2:0]  AWB_STEP      = 3'h2;
  localparam logic [9:0]  BYTE_LIT_MAX  = 10'h0FF;
  localparam logic [2:0]  PAIR_MAX      = 3'h5;
  localparam logic [3:0]  PF_SECOND     = 4'h7;
  localparam logic [3:0]  PF_INDEXED    = 4'hE;
  localparam logic [3:0]  PF_NONE       = 4'hF;
  localparam logic [4:0]  CPU_FLAG_RST  = 5'h00;
  localparam logic [3:0]  DSP_FLAG_RST  = 4'h0;

  typedef enum logic [1:0] {
    DOFD_SZ_WORD  = 2'h0,
    DOFD_SZ_BYTE  = 2'h1,
    DOFD_SZ_DWORD = 2'h2,
    DOFD_SZ_WORD2 = 2'h3
  } dofd_size_e;

  typedef enum logic [1:0] {
    DOFD_AWB_NONE  = 2'h0,
    DOFD_AWB_REG   = 2'h1,
    DOFD_AWB_POST  = 2'h2,
    DOFD_AWB_NONE2 = 2'h3
  } dofd_awb_e;

  typedef enum logic [2:0] {
    DOFD_AM_DIRECT  = 3'h0,
    DOFD_AM_IND     = 3'h1,
    DOFD_AM_POSTINC = 3'h2,
    DOFD_AM_POSTDEC = 3'h3,
    DOFD_AM_PREINC  = 3'h4,
    DOFD_AM_PREDEC  = 3'h5,
    DOFD_AM_INDEX   = 3'h6,
    DOFD_AM_INDEX2  = 3'h7
  } dofd_amode_e;
endpackage

// [rtl/dofd_prefetch_decode.sv]
// decodes one four-bit prefetch address mode code
`timescale 1ns/1ps
`default_nettype none
module dofd_prefetch_decode
  import dofd_pkg::*;
(
  input  wire logic        [3:0] mode_code,
  input  wire logic        [3:0] first_reg,
  output logic             [3:0] addr_reg,
  output logic signed      [3:0] step,
  output logic                   indexed,
  output logic                   enable
);
  logic [3:0] slot;

  always_comb begin
    slot     = (mode_code < PF_SECOND) ? mode_code : mode_code - PF_SECOND;
    enable   = (mode_code != PF_NONE);
    indexed  = (mode_code == PF_INDEXED);
    addr_reg = (mode_code < PF_SECOND) ? first_reg : first_reg + 4'h1;
    step     = 4'sh0;
    if (!indexed && enable) begin
      unique case (slot)
        4'h0:    step = 4'sh6;
        4'h1:    step = 4'sh4;
        4'h2:    step = 4'sh2;
        4'h4:    step = -4'sh6;
        4'h5:    step = -4'sh4;
        4'h6:    step = -4'sh2;
        default: step = 4'sh0;
      endcase
    end
    if (!enable) begin
      addr_reg = 4'h0;
    end
  end
endmodule
`default_nettype wire

// [tb/dofd_decoder_assertions.sv]
// port-level checks for the operand field decoder
`timescale 1ns/1ps
`default_nettype none
module dofd_decoder_checker (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic [23:0] instr_word,
  input wire logic        instr_valid,
  input wire logic [4:0]  alu_flag_we,
  input wire logic [4:0]  alu_flag_in,
  input wire logic [3:0]  dsp_flag_we,
  input wire logic [3:0]  dsp_flag_in,
  input wire logic        dec_valid,
  input wire logic        is_nop,
  input wire logic [7:0]  opcode,
  input wire logic [1:0]  operand_size,
  input wire logic        lit_range_err,
  input wire logic [15:0] ten_bit_signed_literal,
  input wire logic        prog_addr_err,
  input wire logic [3:0]  mul_reg_a,
  input wire logic [3:0]  mul_reg_b,
  input wire logic        x_pf_en,
  input wire logic        carry_flag,
  input wire logic        acc_a_overflow_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  valid_pulse_a: assert property (instr_valid |=> dec_valid)
    else $error("accepted word not flagged");
  idle_hold_a: assert property (!instr_valid |=> !dec_valid && $stable(opcode))
    else $error("fields moved without a word");
  nop_decode_a: assert property (instr_valid |=> is_nop == ($past(instr_word[23:16]) == 8'h00))
    else $error("no-operation decode wrong");
  byte_limit_a: assert property (instr_valid |=> lit_range_err ==
    ($past(instr_word[15:14]) == 2'h1 && $past(instr_word[13:4]) > 10'h0FF))
    else $error("byte literal range flag wrong");
  prog_lsb_a: assert property (instr_valid |=> prog_addr_err == $past(instr_word[0]))
    else $error("program address flag wrong");
  sign_ext_a: assert property (instr_valid |=> ten_bit_signed_literal ==
    {{6{$past(instr_word[13])}}, $past(instr_word[13:4])})
    else $error("signed literal not extended");
  size_dflt_a: assert property (instr_valid && instr_word[15:14] == 2'h3 |=> operand_size == 2'h0)
    else $error("size default wrong");
  pair_order_a: assert property (dec_valid |-> mul_reg_a >= 4'h4 && mul_reg_a < mul_reg_b && mul_reg_b <= 4'h7)
    else $error("multiply pair outside set");
  x_none_a: assert property (instr_valid && instr_word[9:6] == 4'hF |=> !x_pf_en)
    else $error("prefetch enabled on none code");
  carry_load_a: assert property (alu_flag_we[0] |=> carry_flag == $past(alu_flag_in[0]))
    else $error("carry not loaded");
  carry_keep_a: assert property (!alu_flag_we[0] |=> $stable(carry_flag))
    else $error("carry changed unwritten");
  acc_ovf_a: assert property (dsp_flag_we[0] |=> acc_a_overflow_flag == $past(dsp_flag_in[0]))
    else $error("accumulator overflow not loaded");
endmodule
bind dofd_decoder dofd_decoder_checker u_chk (.*);
`default_nettype wire

// [tb/dofd_fetch_model.sv]
// fetch stage model presenting words to the decoder
`timescale 1ns/1ps
`default_nettype none
module dofd_fetch_model (
  input  wire logic        sys_clk,
  output logic      [23:0] instr_word,
  output logic             instr_valid
);
  initial begin
    instr_word = 24'h000000;
    instr_valid = 1'b0;
  end
  // idle slots change the word so no stale value can pass
  task automatic put(input logic [23:0] w, input logic v);
    @(posedge sys_clk);
    instr_valid <= v;
    instr_word <= v ? w : ~instr_word;
  endtask
endmodule
`default_nettype wire

// [tb/dofd_decoder_tb.sv]
// self-checking bench for the operand field decoder
`timescale 1ns/1ps
`default_nettype none
module dofd_decoder_tb
  import dofd_pkg::*;
;
  logic sys_clk, sys_rst, instr_valid, dsp_field_sel, pv, ps, v;
  logic [23:0] instr_word, w, pw;
  logic [4:0] alu_flag_we, alu_flag_in, cpu_exp;
  logic [3:0] dsp_flag_we, dsp_flag_in, dsp_exp;
  logic [31:0] r;
  logic dec_valid, is_nop, mode_err, file_dest_default_working_reg, lit_range_err, prog_addr_err, shadow_sel;
  logic acc_sel, awb_en, awb_indirect, pair_err, x_pf_en, x_pf_indexed, y_pf_en, y_pf_indexed;
  logic carry_flag, digit_carry_flag, negative_flag, overflow_flag, zero_flag;
  logic acc_a_overflow_flag, acc_b_overflow_flag, acc_a_saturate_flag, acc_b_saturate_flag;
  logic [3:0] base_work_reg, src_reg, dst_reg, default_working_reg, bit_position_field;
  logic [3:0] awb_reg, mul_reg_a, mul_reg_b, square_operand_reg, x_pf_reg, x_pf_dest;
  logic [3:0] y_pf_reg, y_pf_dest, pf_index_reg;
  logic signed [3:0] x_pf_step, y_pf_step;
  logic [2:0] src_mode, dst_mode, awb_step;
  logic [1:0] operand_size, acc_writeback_dest;
  logic [7:0] opcode;
  logic [12:0] file_reg_addr;
  logic [9:0] ten_bit_unsigned_literal;
  logic [15:0] ten_bit_signed_literal;
  logic [22:0] program_address_literal;
  logic [7:0] pr [8] = '{8'h45, 8'h46, 8'h47, 8'h56, 8'h57, 8'h67, 8'h45, 8'h45};
  // last corner has a zero top byte: a no-operation word
  logic [23:0] cw [7] = '{24'h105000, 24'h104FF0, 24'h103FF0, 24'h102000, 24'h123457, 24'h10C000,
    24'h00A5C3};
  int failures, total_checks, cycles;

  dofd_decoder uut (.*);
  dofd_fetch_model u_fetch (.sys_clk(sys_clk), .instr_word(instr_word), .instr_valid(instr_valid));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // generous ceiling, the run needs about 420 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  // {en, reg, step, indexed}; codes 0-6 first reg, 7-13 second, 14 indexed, 15 none
  function automatic logic [9:0] pf(input logic [3:0] c, input logic [3:0] r0);
    logic [3:0] st [7] = '{4'h6, 4'h4, 4'h2, 4'h0, 4'hA, 4'hC, 4'hE};
    if (c == 4'hF) return 10'h000;
    if (c == 4'hE) return {1'b1, r0 + 4'h1, 4'h0, 1'b1};
    return {1'b1, c > 4'h6 ? r0 + 4'h1 : r0, st[c > 4'h6 ? c - 4'h7 : c], 1'b0};
  endfunction

  task automatic look(input logic [23:0] x, input logic s);
    chk(dec_valid, 1'b1);
    chk({opcode, is_nop}, {x[23:16], x[23:16] == NOP_OPCODE});
    chk({base_work_reg, src_reg, dst_reg}, {x[19:16], x[3:0], x[10:7]});
    chk({src_mode, dst_mode}, {x[6:4], x[13:11]});
    chk(mode_err, !s && (x[6:5] == 2'h3 || x[13:12] == 2'h3));
    chk({default_working_reg, file_reg_addr, file_dest_default_working_reg}, {4'h0, x[12:0], x[13]});
    chk(bit_position_field, x[15:12]);
    chk({ten_bit_unsigned_literal, lit_range_err}, {x[13:4], x[15:14] == 2'h1 && x[13:4] > 10'h0FF});
    chk({program_address_literal, prog_addr_err}, {x[22:0], x[0]});
    chk(ten_bit_signed_literal, {{6{x[13]}}, x[13:4]});
    chk(operand_size, x[15:14] == 2'h3 ? 2'h0 : x[15:14]);
    chk({shadow_sel, acc_sel}, {x[20], x[15]});
    chk({acc_writeback_dest, awb_en, awb_indirect, awb_reg, awb_step},
      {x[1:0], ^x[1:0], x[1:0] == 2'h2, 4'hD, 3'h2});
    chk({mul_reg_a, mul_reg_b, pair_err}, {pr[x[18:16]], x[18:16] > 3'h5});
    chk(square_operand_reg, 4'h4 + x[17:16]);
    chk({x_pf_en, x_pf_reg, x_pf_step, x_pf_indexed}, pf(x[9:6], 4'h8));
    chk({y_pf_en, y_pf_reg, y_pf_step, y_pf_indexed}, pf(x[5:2], 4'hA));
    chk({x_pf_dest, y_pf_dest, pf_index_reg}, {4'h4 + x[13:12], 4'h4 + x[11:10], 4'hC});
  endtask

  initial begin
    void'($urandom(45));
    sys_rst = 1'b1;
    {dsp_field_sel, alu_flag_we, alu_flag_in, dsp_flag_we, dsp_flag_in} = '0;
    {cpu_exp, dsp_exp, pv, ps} = '0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 400; i++) begin
      // second reset mid-run, flags and outputs must return to rest
      if (i == 300) begin
        @(posedge sys_clk);
        sys_rst     <= 1'b1;
        alu_flag_we <= 5'h00;
        dsp_flag_we <= 4'h0;
        u_fetch.put(24'h000000, 1'b0);
        #1;
        chk({dec_valid, is_nop, opcode, mul_reg_a, mul_reg_b, square_operand_reg, x_pf_dest,
          y_pf_dest, operand_size}, 32'h40111110);
        @(posedge sys_clk);
        sys_rst <= 1'b0;
        {cpu_exp, dsp_exp, pv} = '0;
      end
      r = $urandom;
      w = 24'($urandom);
      v = (i < 30) || (r[21:20] != 2'h0);
      if (i < 16) begin
        w[9:6] = i[3:0];
        w[5:2] = ~i[3:0];
        w[18:16] = i[2:0];
        w[1:0] = i[1:0];
      end else if (i < 23) begin
        w = cw[i - 16];
      end
      u_fetch.put(w, v);
      alu_flag_we <= r[4:0];
      alu_flag_in <= r[9:5];
      dsp_flag_we <= r[13:10];
      dsp_flag_in <= r[17:14];
      dsp_field_sel <= r[18];
      #1;
      if (pv) look(pw, ps);
      else chk(dec_valid, 1'b0);
      chk({zero_flag, overflow_flag, negative_flag, digit_carry_flag, carry_flag}, cpu_exp);
      chk({acc_b_saturate_flag, acc_a_saturate_flag, acc_b_overflow_flag, acc_a_overflow_flag},
        dsp_exp);
      cpu_exp = (cpu_exp & ~r[4:0]) | (r[9:5] & r[4:0]);
      dsp_exp = (dsp_exp & ~r[13:10]) | (r[17:14] & r[13:10]);
      {pw, pv, ps} = {w, v, r[18]};
    end
    end_of_test();
  end
endmodule
`default_nettype wire
